/* slave_port_map.vh */
// constants for the parallel slave port: offsets, fields, resets, phases
`ifndef SLAVE_PORT_MAP_VH
`define SLAVE_PORT_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_DATA        8'h00
`define OFS_PORT_E_DIR  8'h04
`define OFS_CONV_CTRL   8'h08
`define OFS_IRQ_FLAGS   8'h0C
`define OFS_IRQ_ENABLES 8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_IN_FULL     7
`define BIT_OUT_FULL    6
`define BIT_OVERFLOW    5
`define BIT_SELECT      4
`define BIT_SP_IRQ      7
`define DIR_HI          2
`define APC_HI          2

// ****************************************************************
// reset values and codes
// ****************************************************************
`define DIR_ALL_INPUT   3'h7
`define APC_RESET       3'h0
`define APC_DIGITAL     3'h7
`define BYTE_RESET      8'h00
`define PINS_IDLE       11'h7FF
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ****************************************************************
// four-phase instruction clock, one phase per clock
// ****************************************************************
`define PHASE_Q2        2'h1
`define PHASE_Q4        2'h3

`endif

/* pin_sync.v */
// two-flop synchroniser for the port pins
module pin_sync #(
  parameter             W       = 11,        // number of bits
  parameter [W-1:0]     IDLE    = {W{1'b1}}  // level held in reset
) (
  input  wire           clk,                 // system clock
  input  wire           rst_n,               // async reset, active low
  input  wire [W-1:0]   din,                 // raw pin levels
  output reg  [W-1:0]   dout                 // synchronised levels
);

  reg [W-1:0] meta_q;                         // first stage, read only below

  // ****************************************************************
  // two stages; only the second stage is seen by logic
  // ****************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= IDLE;
      dout   <= IDLE;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

/* slave_port.v */
// parallel slave port with an axi4-lite register slave
`include "slave_port_map.vh"

module slave_port #(
  parameter           AW = 8                 // axi address width
) (
  input  wire          SYS_CLK,              // 10 MHz system clock
  input  wire          RESETN,               // async reset, active low
  input  wire [AW-1:0] AWADDR,               // write address
  input  wire          AWVALID,              // write address valid
  output reg           AWREADY,              // write address ready
  input  wire [31:0]   WDATA,                // write data
  input  wire [3:0]    WSTRB,                // write byte strobes
  input  wire          WVALID,               // write data valid
  output reg           WREADY,               // write data ready
  output reg  [1:0]    BRESP,                // write response
  output reg           BVALID,               // write response valid
  input  wire          BREADY,               // write response ready
  input  wire [AW-1:0] ARADDR,               // read address
  input  wire          ARVALID,              // read address valid
  output reg           ARREADY,              // read address ready
  output reg  [31:0]   RDATA,                // read data
  output reg  [1:0]    RRESP,                // read response
  output reg           RVALID,               // read data valid
  input  wire          RREADY,               // read data ready
  input  wire          RD_N,                 // host read strobe, pin 0
  input  wire          WR_N,                 // host write strobe, pin 1
  input  wire          CS_N,                 // host chip select, pin 2
  input  wire [7:0]    PD_IN,                // port D pin levels
  output reg  [7:0]    PD_OUT,               // port D drive value
  output reg           PD_OE,                // port D drive enable
  output reg           IRQ                   // level interrupt
);

  // ****************************************************************
  // completion stage codes
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'h0;           // nothing pending
  localparam [1:0] ST_Q2   = 2'h1;           // waiting next second phase
  localparam [1:0] ST_Q4   = 2'h2;           // waiting following fourth

  // ****************************************************************
  // declarations
  // ****************************************************************
  wire [10:0] pins_s;                         // synchronised pins
  wire        rd_s;                           // read strobe, synced
  wire        wr_s;                           // write strobe, synced
  wire        cs_s;                           // chip select, synced
  wire [7:0]  pd_s;                           // port D data, synced

  reg         select_q;                       // slave port select
  reg  [2:0]  dir_q;                          // port E direction bits
  reg  [2:0]  apc_q;                          // analog pin config
  reg         in_full_q;                      // input full flag
  reg         out_full_q;                     // output full flag
  reg         overflow_q;                     // input overflow flag
  reg         irq_flag_q;                     // slave port irq flag
  reg         irq_en_q;                       // slave port irq enable
  reg  [7:0]  in_latch_q;                     // byte from host
  reg  [7:0]  out_latch_q;                    // byte for host
  reg  [1:0]  phase_q;                        // instruction phase
  reg         wr_act_q;                       // host write in progress
  reg         rd_act_q;                       // host read in progress
  reg  [1:0]  wr_st_q;                        // write completion stage
  reg  [1:0]  rd_st_q;                        // read completion stage

  reg         aw_hold_q;                      // write address taken
  reg         w_hold_q;                       // write data taken
  reg [AW-1:0] awaddr_q;                      // held write address
  reg  [31:0] wdata_q;                        // held write data
  reg  [3:0]  wstrb_q;                        // held byte strobes

  // ****************************************************************
  // completion helpers, shared by write and read paths
  // ****************************************************************
  // stage advance: end restarts, then next q2, then following q4
  function [1:0] stage_next;
    input [1:0] st;
    input       ended;
    input [1:0] ph;
    begin
      if (ended) begin
        stage_next = ST_Q2;
      end else if (st == ST_Q2 && ph == `PHASE_Q2) begin
        stage_next = ST_Q4;
      end else if (st == ST_Q4 && ph == `PHASE_Q4) begin
        stage_next = ST_IDLE;
      end else begin
        stage_next = st;
      end
    end
  endfunction

  // completion fires in the fourth phase of the waiting stage
  function stage_done;
    input [1:0] st;
    input [1:0] ph;
    begin
      stage_done = (st == ST_Q4) && (ph == `PHASE_Q4);
    end
  endfunction

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  // host runs without our clock, so all pins pass two flops
  pin_sync #(
    .W    (11),
    .IDLE (`PINS_IDLE)
  ) u_sync (
    .clk   (SYS_CLK),
    .rst_n (RESETN),
    .din   ({CS_N, WR_N, RD_N, PD_IN}),
    .dout  (pins_s)
  );

  assign cs_s = pins_s[10];
  assign wr_s = pins_s[9];
  assign rd_s = pins_s[8];
  assign pd_s = pins_s[7:0];

  // ****************************************************************
  // strobe qualification
  // ****************************************************************
  // strobes count only with pins as inputs and digital config
  wire pins_ok = select_q && (dir_q == `DIR_ALL_INPUT)
                 && (apc_q == `APC_DIGITAL);
  wire wr_low  = pins_ok && !cs_s && !wr_s;
  wire rd_low  = pins_ok && !cs_s && !rd_s;
  wire wr_end  = wr_act_q && !wr_low;            // level sensed end
  wire rd_end  = rd_act_q && !rd_low;            // level sensed end
  wire rd_start = rd_low && !rd_act_q;           // first seen low
  wire wr_done = stage_done(wr_st_q, phase_q);
  wire rd_done = stage_done(rd_st_q, phase_q);

  // ****************************************************************
  // axi handshakes
  // ****************************************************************
  wire aw_take = AWVALID && AWREADY;              // address accepted
  wire w_take  = WVALID && WREADY;                // data accepted
  wire wr_do   = aw_hold_q && w_hold_q && !BVALID; // perform the write
  wire ar_take = ARVALID && ARREADY;              // read accepted

  wire w_data  = wr_do && awaddr_q == `OFS_DATA && wstrb_q[0];
  wire w_dir   = wr_do && awaddr_q == `OFS_PORT_E_DIR && wstrb_q[0];
  wire w_conv  = wr_do && awaddr_q == `OFS_CONV_CTRL && wstrb_q[0];
  wire w_flags = wr_do && awaddr_q == `OFS_IRQ_FLAGS && wstrb_q[0];
  wire w_ens   = wr_do && awaddr_q == `OFS_IRQ_ENABLES && wstrb_q[0];
  wire w_hit   = awaddr_q == `OFS_DATA || awaddr_q == `OFS_PORT_E_DIR
                 || awaddr_q == `OFS_CONV_CTRL
                 || awaddr_q == `OFS_IRQ_FLAGS
                 || awaddr_q == `OFS_IRQ_ENABLES;
  wire r_data  = ar_take && ARADDR == `OFS_DATA;
  wire r_flags = ar_take && ARADDR == `OFS_IRQ_FLAGS;

  // ****************************************************************
  // read data mux
  // ****************************************************************
  reg [7:0] rd_byte;                             // selected register
  reg       rd_hit;                              // address mapped
  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (ARADDR)
      `OFS_DATA:        rd_byte = in_latch_q;
      `OFS_PORT_E_DIR: begin
        rd_byte[`BIT_IN_FULL]  = in_full_q;
        rd_byte[`BIT_OUT_FULL] = out_full_q;
        rd_byte[`BIT_OVERFLOW] = overflow_q;
        rd_byte[`BIT_SELECT]   = select_q;
        rd_byte[`DIR_HI:0]     = dir_q;
      end
      `OFS_CONV_CTRL:   rd_byte[`APC_HI:0] = apc_q;
      `OFS_IRQ_FLAGS:   rd_byte[`BIT_SP_IRQ] = irq_flag_q;
      `OFS_IRQ_ENABLES: rd_byte[`BIT_SP_IRQ] = irq_en_q;
      default:          rd_hit = 1'b0;           // unmapped reads zero
    endcase
  end

  // ****************************************************************
  // axi write channel
  // ****************************************************************
  // one write at a time; address and data taken in either order
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      AWREADY   <= 1'b0;
      WREADY    <= 1'b0;
      BVALID    <= 1'b0;
      BRESP     <= `RESP_OKAY;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= {AW{1'b0}};
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
    end else begin
      AWREADY <= !aw_hold_q && !aw_take && !BVALID;
      WREADY  <= !w_hold_q && !w_take && !BVALID;
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= AWADDR;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        wdata_q  <= WDATA;
        wstrb_q  <= WSTRB;
      end
      if (wr_do) begin                           // response after both
        BVALID    <= 1'b1;
        BRESP     <= w_hit ? `RESP_OKAY : `RESP_SLVERR;
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // axi read channel
  // ****************************************************************
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= `RESP_OKAY;
    end else begin
      ARREADY <= !RVALID && !ar_take;            // one read at a time
      if (ar_take) begin
        RVALID <= 1'b1;
        RDATA  <= {24'h000000, rd_byte};
        RRESP  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      select_q    <= 1'b0;
      dir_q       <= `DIR_ALL_INPUT;
      apc_q       <= `APC_RESET;
      irq_en_q    <= 1'b0;
      out_latch_q <= `BYTE_RESET;
    end else begin
      if (w_dir) begin
        select_q <= wdata_q[`BIT_SELECT];
        dir_q    <= wdata_q[`DIR_HI:0];
      end
      if (w_conv) begin
        apc_q <= wdata_q[`APC_HI:0];
      end
      if (w_ens) begin
        irq_en_q <= wdata_q[`BIT_SP_IRQ];
      end
      if (w_data) begin                          // firmware side latch
        out_latch_q <= wdata_q[7:0];
      end
    end
  end

  // ****************************************************************
  // phase counter and host transfer tracking
  // ****************************************************************
  // the four-phase clock is modelled as one phase per system clock
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      phase_q    <= 2'h0;
      wr_act_q   <= 1'b0;
      rd_act_q   <= 1'b0;
      wr_st_q    <= ST_IDLE;
      rd_st_q    <= ST_IDLE;
      in_latch_q <= `BYTE_RESET;
    end else begin
      phase_q  <= phase_q + 2'h1;
      wr_act_q <= wr_low;
      rd_act_q <= rd_low;
      wr_st_q  <= stage_next(wr_st_q, wr_end, phase_q);
      rd_st_q  <= stage_next(rd_st_q, rd_end, phase_q);
      if (wr_low) begin                          // host data follows
        in_latch_q <= pd_s;
      end
    end
  end

  // ****************************************************************
  // status flags
  // ****************************************************************
  // hardware set or clear wins over firmware in the same cycle
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      in_full_q  <= 1'b0;
      out_full_q <= 1'b0;
      overflow_q <= 1'b0;
    end else begin
      if (!select_q) begin
        in_full_q  <= 1'b0;
        out_full_q <= 1'b0;
      end else begin
        if (wr_done) begin
          in_full_q <= 1'b1;
        end else if (r_data) begin
          in_full_q <= 1'b0;
        end
        if (rd_start) begin
          out_full_q <= 1'b0;
        end else if (w_data) begin
          out_full_q <= 1'b1;
        end
      end
      // overflow survives deselect; firmware clears by writing zero
      if (wr_done && in_full_q && !r_data) begin
        overflow_q <= 1'b1;
      end else if (w_dir && !wdata_q[`BIT_OVERFLOW]) begin
        overflow_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // interrupt flag and output
  // ****************************************************************
  // cleared by a read of the flag register or by writing zero
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_flag_q <= 1'b0;
      IRQ        <= 1'b0;
    end else begin
      if (wr_done || rd_done) begin
        irq_flag_q <= 1'b1;
      end else if (r_flags) begin
        irq_flag_q <= 1'b0;
      end else if (w_flags && !wdata_q[`BIT_SP_IRQ]) begin
        irq_flag_q <= 1'b0;
      end
      IRQ <= irq_flag_q && irq_en_q;
    end
  end

  // ****************************************************************
  // port D drive
  // ****************************************************************
  // direction comes from the host read strobe and chip select gated by pins_ok; one clock of lag
  // after the synchroniser, so the host must allow for it
  always @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PD_OE  <= 1'b0;
      PD_OUT <= `BYTE_RESET;
    end else begin
      PD_OE  <= rd_low;
      PD_OUT <= out_latch_q;
    end
  end

endmodule

/* slave_port_props.sv */
// assertions on the slave port pins and the register bus
module slave_port_props #(
  parameter AW = 8                       // axi address width
) (
  input wire        SYS_CLK,             // system clock
  input wire        RESETN,              // async reset, active low
  input wire        AWVALID,             // write address valid
  input wire        AWREADY,             // write address ready
  input wire        WVALID,              // write data valid
  input wire        WREADY,              // write data ready
  input wire        BVALID,              // write response valid
  input wire        BREADY,              // write response ready
  input wire        ARVALID,             // read address valid
  input wire        ARREADY,             // read address ready
  input wire [31:0] RDATA,               // read data
  input wire        RVALID,              // read data valid
  input wire        RREADY,              // read data ready
  input wire        RD_N,                // host read strobe
  input wire        CS_N,                // host chip select
  input wire        PD_OE                // port D drive enable
);
  // ****************************************************************
  // helpers and sequences
  // ****************************************************************
  wire rd_on;                            // host read strobe pair low
  assign rd_on = !CS_N && !RD_N;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);
  sequence s_rd_off;
    !rd_on;
  endsequence
  sequence s_wr_take;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  // drive only inside an external read, three edges of sync delay
  a_oe_rise: assert property ($rose(PD_OE) |-> $past(rd_on, 3))
    else $error("port drive began without a host read");
  a_oe_fall: assert property ($fell(PD_OE) |-> !$past(rd_on, 3))
    else $error("port drive ended inside a host read");
  a_oe_idle: assert property (s_rd_off [*5] |-> !PD_OE)
    else $error("port driven while no host read");
  a_write_answer: assert property (s_wr_take |=> !BVALID ##1 BVALID)
    else $error("write response not two cycles after take");
  a_aw_busy: assert property (AWVALID && AWREADY |=> !AWREADY)
    else $error("write address ready stayed high after take");
  a_b_drop: assert property (BVALID && BREADY |=> !BVALID)
    else $error("write response held after handshake");
  a_read_answer: assert property (ARVALID && ARREADY |=>
    RVALID && RDATA[31:8] == 24'h0)
    else $error("read data late or upper bits set");
  a_r_drop: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read data held after handshake");
endmodule

bind slave_port slave_port_props #(.AW(AW)) props (
  .SYS_CLK(SYS_CLK), .RESETN(RESETN), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
  .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
  .RD_N(RD_N), .CS_N(CS_N), .PD_OE(PD_OE));

/* host_port.sv */
// model of the external byte-wide bus master on port D
module host_port #(
  parameter HOLD = 6                     // strobe low and high time
) (
  input  wire logic       clk,           // system clock
  output logic            cs_n,          // chip select, active low
  output logic            wr_n,          // write strobe, active low
  output logic            rd_n,          // read strobe, active low
  output logic [7:0]      pd_in,         // levels seen on port D
  input  wire logic [7:0] pd_out,        // value the port drives
  input  wire logic       pd_oe          // port drive enable
);
  logic [7:0] bus_q;                     // last byte put on the pins
  logic       drv_q;                     // host drives the pins
  // released pins show the inverse so stale data never matches
  assign pd_in = pd_oe ? pd_out : (drv_q ? bus_q : ~bus_q);
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    bus_q = 8'h00;
    drv_q = 1'b0;
  end
  // one byte written, strobes held HOLD cycles either way
  task automatic hwrite(input logic [7:0] d);
    @(posedge clk);
    bus_q <= d;
    drv_q <= 1'b1;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    repeat (HOLD) @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    drv_q <= 1'b0;
    repeat (HOLD) @(posedge clk);
  endtask
  // one byte read; an undriven bus gives the inverse
  task automatic hread(output logic [7:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (HOLD) @(posedge clk);
    d = pd_oe ? pd_out : ~pd_out;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (HOLD) @(posedge clk);
  endtask
endmodule

/* testbench.sv */
// self-checking bench for the parallel slave port
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        SYS_CLK, RESETN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, PD_OE;
  logic        RD_N, WR_N, CS_N;     // host strobes
  logic [7:0]  AWADDR, ARADDR, PD_IN, PD_OUT, b, b2;
  logic [31:0] WDATA, RDATA, rd;     // bus data, last read word
  logic [1:0]  BRESP, RRESP, rr, br; // responses, last read and write
  logic [3:0]  WSTRB;                // write byte strobes
  integer      err_count, checks, seed, i, n;
  slave_port dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .RD_N(RD_N), .WR_N(WR_N), .CS_N(CS_N),
    .PD_IN(PD_IN), .PD_OUT(PD_OUT), .PD_OE(PD_OE), .IRQ(IRQ));
  host_port host (.clk(SYS_CLK), .cs_n(CS_N), .wr_n(WR_N), .rd_n(RD_N),
    .pd_in(PD_IN), .pd_out(PD_OUT), .pd_oe(PD_OE));
  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  // ****************************************************************
  // checking and bus tasks
  // ****************************************************************
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // status word: in full, out full, overflow, select, direction 7
  function automatic logic [31:0] st(input logic i, o, v, s);
    return {24'h0, i, o, v, s, 4'h7};
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
    AWADDR <= a;
    WDATA <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1 && n < 50);
    br = BRESP;
    BREADY <= 1'b0;
    @(posedge SYS_CLK);
    if (n >= 50) begin
      err_count++;
      close_out();
    end
  endtask
  task automatic axi_rd(input logic [7:0] a);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1 && n < 50);
    rd = RDATA;
    rr = RRESP;
    RREADY <= 1'b0;
    @(posedge SYS_CLK);
    if (n >= 50) begin
      err_count++;
      close_out();
    end
  endtask
  // completion lands within a few phases; thirty cycles is ample
  task automatic wait_irq(input logic e);
    for (n = 0; n < 30 && IRQ !== 1'b1; n++) @(posedge SYS_CLK);
    chk("irq", {31'h0, IRQ}, {31'h0, e});
    if (e && IRQ !== 1'b1) close_out();
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    err_count = 0;
    checks = 0;
    seed = 32'h4A7A;
    {RESETN, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h00;
    {AWADDR, ARADDR, WDATA} = 48'h0;
    WSTRB = 4'hF;
    repeat (6) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    @(posedge SYS_CLK);
    axi_rd(8'h04);
    chk("status", rd, st(0, 0, 0, 0));
    axi_rd(8'h14);
    chk("resp", {30'h0, rr}, 32'h2);
    axi_wr(8'h14, 8'hFF);
    chk("bresp", {30'h0, br}, 32'h2);
    // strobes stay dead while the pins are analog
    axi_wr(8'h04, 8'h17);
    chk("bresp", {30'h0, br}, 32'h0);
    axi_wr(8'h10, 8'h80);
    host.hwrite(8'h5A);
    wait_irq(1'b0);
    axi_wr(8'h08, 8'h07);
    for (i = 0; i < 5; i++) begin
      b = $random(seed);
      host.hwrite(b);
      wait_irq(1'b1);
      axi_rd(8'h04);
      chk("status", rd, st(1, 0, 0, 1));
      axi_rd(8'h0C);
      chk("flags", rd, 32'h80);
      axi_rd(8'h00);
      chk("data", rd, {24'h0, b});
      axi_rd(8'h04);
      chk("status", rd, st(0, 0, 0, 1));
    end
    // masked: second unread write overflows, flag still latches
    axi_wr(8'h10, 8'h00);
    b = $random(seed);
    b2 = ~b;
    host.hwrite(b);
    host.hwrite(b2);
    wait_irq(1'b0);
    axi_rd(8'h04);
    chk("status", rd, st(1, 0, 1, 1));
    axi_rd(8'h00);
    chk("data", rd, {24'h0, b2});
    host.hwrite(b);
    axi_wr(8'h04, 8'h27);
    axi_rd(8'h04);
    chk("status", rd, st(0, 0, 1, 0));
    axi_wr(8'h04, 8'h17);
    axi_rd(8'h04);
    chk("status", rd, st(0, 0, 0, 1));
    axi_wr(8'h10, 8'h80);
    axi_rd(8'h0C);
    chk("flags", rd, 32'h80);
    // a write with byte 0 strobe off must leave the enable alone
    WSTRB <= 4'h0;
    axi_wr(8'h10, 8'h00);
    WSTRB <= 4'hF;
    axi_rd(8'h10);
    chk("enable", rd, 32'h80);
    // firmware byte read out by the host
    b = $random(seed);
    axi_wr(8'h00, b);
    axi_rd(8'h04);
    chk("status", rd, st(0, 1, 0, 1));
    host.hread(b2);
    chk("host byte", {24'h0, b2}, {24'h0, b});
    wait_irq(1'b1);
    axi_rd(8'h04);
    chk("status", rd, st(0, 0, 0, 1));
    close_out();
  end
endmodule
